// File: eeprom_latch_mem.sv
/*
 sixteen-word write latch storage for the eeprom controller.
 assumes one clock; read data come from a register one cycle later.
*/
`default_nettype none
`include "eeprom_unlock_regs.svh"

module eeprom_latch_mem (
   // clock and reset
   input  wire logic                    clk_i,
   input  wire logic                    rst_n_i,
   // write side
   input  wire logic                    we_i,
   input  wire logic [`LATCH_AW-1:0]    waddr_i,
   input  wire logic [15:0]             wdata_i,
   // read side
   input  wire logic [`LATCH_AW-1:0]    raddr_i,
   output logic      [15:0]             rdata_o
);

   logic [15:0] mem_r [`LATCH_DEPTH];

   always_ff @(posedge clk_i) begin
      if (we_i) begin
         mem_r[waddr_i] <= wdata_i;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_o <= 16'h0000;
      end else begin
         rdata_o <= mem_r[raddr_i];
      end
   end

endmodule : eeprom_latch_mem

`default_nettype wire

// File: eeprom_unlock_checker.sv
/*
 checker for the eeprom write unlock controller, bound to its top.
 assumes the register header and the fixed 100000-cycle count.
*/
`default_nettype none
`include "eeprom_unlock_regs.svh"

module eeprom_unlock_checker (
   // clock and reset
   input wire logic        clk_i,
   input wire logic        rst_n_i,
   // register port
   input wire logic [15:0] reg_addr_i,
   input wire logic [15:0] reg_wdata_i,
   input wire logic        reg_wr_i,
   input wire logic        reg_rd_i,
   input wire logic [15:0] reg_rdata_o,
   // flag and array
   input wire logic        done_clear_i,
   input wire logic        done_flag_o,
   input wire logic        array_busy_o
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int LEN_MIN = 99990;
   localparam int LEN_MAX = 100010;
   logic        k1_r;
   logic        k2_r;
   logic [1:0]  go_r;
   logic [16:0] len_r;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   // key pair then start write; only other writes break the pair
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         k1_r  <= 1'b0;
         k2_r  <= 1'b0;
         go_r  <= 2'b00;
         len_r <= 17'h0;
      end else begin
         if (reg_wr_i) begin
            k1_r <= reg_addr_i == `OFS_UNLOCK_CODE && reg_wdata_i[7:0] == `KEY_FIRST;
            k2_r <= k1_r && reg_addr_i == `OFS_UNLOCK_CODE
                    && reg_wdata_i[7:0] == `KEY_SECOND;
         end
         go_r  <= {go_r[0], k2_r && reg_wr_i && reg_addr_i == `OFS_OP_CONTROL
                  && reg_wdata_i[`BIT_START]};
         len_r <= array_busy_o ? len_r + 17'h1 : 17'h0;
      end
   end

   sequence cycle_end_s;
      $past(array_busy_o) ##[0:1] !array_busy_o;
   endsequence

   start_gated_a: assert property ($rose(array_busy_o) |-> |go_r)
      else $error("cycle began without key pair");
   busy_hold_a: assert property ($rose(array_busy_o) |=> array_busy_o[*8])
      else $error("cycle cut short");
   busy_len_a: assert property ($fell(array_busy_o)
      |-> len_r >= LEN_MIN && len_r <= LEN_MAX)
      else $error("cycle length wrong");
   done_set_a: assert property ($rose(done_flag_o) |-> cycle_end_s)
      else $error("done flag not tied to cycle end");
   done_sticky_a: assert property (done_flag_o && !done_clear_i |=> done_flag_o)
      else $error("done flag dropped by itself");
   done_clear_a: assert property (done_flag_o && done_clear_i && !array_busy_o |=> !done_flag_o)
      else $error("done flag not cleared");
   rdata_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 16'h0)
      else $error("read data outside read slot");
   key_read_a: assert property ($past(reg_rd_i && reg_addr_i == `OFS_UNLOCK_CODE)
      |-> reg_rdata_o == 16'h0)
      else $error("unlock code readable");
   high_read_a: assert property ($past(reg_rd_i && reg_addr_i == `OFS_ADDR_HIGH)
      |-> (reg_rdata_o & ~`ADDR_HIGH_MASK) == 16'h0)
      else $error("upper address spare bits set");
   ctrl_read_a: assert property ($past(reg_rd_i && reg_addr_i == `OFS_OP_CONTROL)
      |-> (reg_rdata_o & ~`OP_CONTROL_MASK) == 16'h0)
      else $error("control spare bits set");
endmodule : eeprom_unlock_checker

bind eeprom_write_unlock_controller eeprom_unlock_checker chk_i (
   .clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
   .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
   .done_clear_i(done_clear_i), .done_flag_o(done_flag_o), .array_busy_o(array_busy_o)
);

`default_nettype wire

// File: eeprom_unlock_pkg.sv
/*
 types shared by the eeprom write unlock controller.
 assumes nothing from the register header; sizes are written out here.
*/
`default_nettype none

package eeprom_unlock_pkg;

   typedef enum logic [1:0] {
      KEY_IDLE  = 2'b00,
      KEY_FIRST = 2'b01,
      KEY_READY = 2'b10
   } key_state_t;

   typedef struct packed {
      logic [15:0] addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } reg_req_t;

   typedef struct packed {
      logic        wr;
      logic [22:0] addr;
      logic [15:0] data;
   } latch_wr_t;

endpackage : eeprom_unlock_pkg

`default_nettype wire

// File: eeprom_unlock_regs.svh
/*
 register offsets, field positions, reset values and timing counts
 for the eeprom write unlock controller; included by bare name.
*/
`ifndef EEPROM_UNLOCK_REGS_SVH
`define EEPROM_UNLOCK_REGS_SVH

`define OFS_OP_CONTROL     16'h0760
`define OFS_ADDR_LOW       16'h0762
`define OFS_ADDR_HIGH      16'h0764
`define OFS_UNLOCK_CODE    16'h0766

`define BIT_START          15
`define BIT_ARM            14
`define BIT_FAULT          13
`define BIT_TERMINATED     8
`define OPSEL_MSB          6
`define OPSEL_LSB          0
`define OP_CONTROL_MASK    16'he17f
`define OP_CONTROL_RESET   16'h0000
`define ADDR_HIGH_MASK     16'h007f

`define KEY_FIRST          8'h55
`define KEY_SECOND         8'haa

`define OP_WORD_PROGRAM    7'h04
`define OP_BLOCK_PROGRAM   7'h0a
`define OP_WORD_ERASE      7'h44
`define OP_BLOCK_ERASE     7'h45

`define CLK_HZ             50000000
`define CYCLE_TIME_US      2000
`define CYCLE_COUNT        ((`CYCLE_TIME_US * (`CLK_HZ / 1000000)))

`define LATCH_DEPTH        16
`define LATCH_AW           4

`endif

// File: eeprom_write_unlock_controller.sv
/*
 eeprom write unlock controller: control, target address pair and
 unlock code registers, unlock sequence tracker, write latches and
 the timed erase/program cycle.
 assumes a simple register port from the cpu and a table-write port
 on the same clock; the array itself sits outside, fed by the
 array strobe outputs.
*/
`default_nettype none
`include "eeprom_unlock_regs.svh"

module eeprom_write_unlock_controller (
   // clock and reset
   input  wire logic                        clk_i,
   input  wire logic                        rst_n_i,
   // register port
   input  wire logic [15:0]                 reg_addr_i,
   input  wire logic [15:0]                 reg_wdata_i,
   input  wire logic                        reg_wr_i,
   input  wire logic                        reg_rd_i,
   output logic      [15:0]                 reg_rdata_o,
   // table write port
   input  wire logic                        tbl_wr_i,
   input  wire logic [22:0]                 tbl_addr_i,
   input  wire logic [15:0]                 tbl_data_i,
   // done flag
   input  wire logic                        done_clear_i,
   output logic                             done_flag_o,
   // array side
   output logic                             array_busy_o,
   output logic                             array_erase_o,
   output logic                             array_program_o,
   output logic                             array_block_o,
   output logic      [22:0]                 array_addr_o,
   output logic      [15:0]                 array_data_o
);

   localparam int unsigned TICKS_PER_US = `CLK_HZ / 1000000;
   localparam int unsigned CYCLE_US     = `CYCLE_TIME_US;

   eeprom_unlock_pkg::reg_req_t  req;
   eeprom_unlock_pkg::latch_wr_t tbl;
   eeprom_unlock_pkg::key_state_t key_r;
   eeprom_unlock_pkg::key_state_t key_nxt;

   logic        start_r;
   logic        arm_r;
   logic        fault_r;
   logic        term_r;
   logic [6:0]  opsel_r;
   logic [15:0] addr_low_r;
   logic [6:0]  addr_high_r;
   logic [10:0] timer_r;
   logic [5:0]  div_r;
   logic        us_tick;
   logic        op_erase;
   logic        op_block;
   logic [3:0]  step_r;
   logic        done_r;
   logic        start_ok;
   logic        wr_ctl;
   logic        wr_key;
   logic [15:0] rd_nxt;
   logic [3:0]  mem_raddr;
   logic [15:0] mem_rdata;

   assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};
   assign tbl = '{wr: tbl_wr_i, addr: tbl_addr_i, data: tbl_data_i};
   assign wr_ctl = req.wr && (req.addr == `OFS_OP_CONTROL);
   assign wr_key = req.wr && (req.addr == `OFS_UNLOCK_CODE);

   // unlock tracker; any other register write knocks it back
   always_comb begin
      key_nxt = key_r;
      if (req.wr) begin
         unique case (key_r)
            eeprom_unlock_pkg::KEY_IDLE: begin
               key_nxt = (wr_key && req.wdata[7:0] == `KEY_FIRST)
                         ? eeprom_unlock_pkg::KEY_FIRST
                         : eeprom_unlock_pkg::KEY_IDLE;
            end
            eeprom_unlock_pkg::KEY_FIRST: begin
               key_nxt = (wr_key && req.wdata[7:0] == `KEY_SECOND)
                         ? eeprom_unlock_pkg::KEY_READY
                         : eeprom_unlock_pkg::KEY_IDLE;
            end
            eeprom_unlock_pkg::KEY_READY: begin
               key_nxt = eeprom_unlock_pkg::KEY_IDLE;
            end
            default: begin
               key_nxt = eeprom_unlock_pkg::KEY_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         key_r <= eeprom_unlock_pkg::KEY_IDLE;
      end else begin
         key_r <= key_nxt;
      end
   end

   // arm must already be set and stay set in this very write
   assign start_ok = wr_ctl && req.wdata[`BIT_START] && !start_r
                     && arm_r && req.wdata[`BIT_ARM]
                     && (key_r == eeprom_unlock_pkg::KEY_READY);

   // control register; arm written only by software
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         arm_r   <= 1'b0;
         fault_r <= 1'b0;
         term_r  <= 1'b0;
         opsel_r <= 7'h00;
      end else if (wr_ctl) begin
         arm_r   <= req.wdata[`BIT_ARM];
         fault_r <= req.wdata[`BIT_FAULT];
         term_r  <= req.wdata[`BIT_TERMINATED];
         if (!start_r) begin
            opsel_r <= req.wdata[`OPSEL_MSB:`OPSEL_LSB];
         end
      end
   end

   // microsecond enable; keeps the cycle counter narrow
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         div_r <= 6'h00;
      end else if (!start_r || us_tick) begin
         div_r <= 6'h00;
      end else begin
         div_r <= div_r + 6'h01;
      end
   end

   assign us_tick = start_r && (div_r == 6'(TICKS_PER_US - 1));

   // cycle timer in microseconds; the cpu is never stalled, it just polls
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         start_r <= 1'b0;
         timer_r <= 11'h000;
      end else if (start_r) begin
         if (done_r) begin
            start_r <= 1'b0;
            timer_r <= 11'h000;
         end else if (us_tick) begin
            timer_r <= timer_r + 11'h001;
         end
      end else if (start_ok) begin
         start_r <= 1'b1;
         timer_r <= 11'h000;
      end
   end

   assign done_r = us_tick && (timer_r == 11'(CYCLE_US - 1));

   // sticky done flag; a completion beats a same-cycle clear
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         done_flag_o <= 1'b0;
      end else if (done_r) begin
         done_flag_o <= 1'b1;
      end else if (done_clear_i) begin
         done_flag_o <= 1'b0;
      end
   end

   // target address: software writes or last table write
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         addr_low_r  <= 16'h0000;
         addr_high_r <= 7'h00;
      end else if (tbl.wr && !start_r) begin // running cycle keeps its address
         addr_low_r  <= tbl.addr[15:0];
         addr_high_r <= tbl.addr[22:16];
      end else if (req.wr && !start_r) begin
         if (req.addr == `OFS_ADDR_LOW) begin
            addr_low_r <= req.wdata;
         end
         if (req.addr == `OFS_ADDR_HIGH) begin
            addr_high_r <= req.wdata[6:0];
         end
      end
   end

   // write latches; block program walks all sixteen during the cycle
   eeprom_latch_mem u_latch (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .we_i    (tbl.wr && !start_r),
      .waddr_i (tbl.addr[4:1]),
      .wdata_i (tbl.data),
      .raddr_i (mem_raddr),
      .rdata_o (mem_rdata)
   );

   assign mem_raddr = (opsel_r == `OP_BLOCK_PROGRAM) ? step_r : addr_low_r[4:1];

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         step_r <= 4'h0;
      end else if (!start_r) begin
         step_r <= 4'h0;
      end else if (opsel_r == `OP_BLOCK_PROGRAM && step_r != 4'hf) begin
         step_r <= step_r + 4'h1;
      end
   end

   // operation decode; unlisted codes run as a single-word program
   always_comb begin
      op_erase = 1'b0;
      op_block = 1'b0;
      unique case (opsel_r)
         `OP_WORD_ERASE: begin
            op_erase = 1'b1;
         end
         `OP_BLOCK_ERASE: begin
            op_erase = 1'b1;
            op_block = 1'b1;
         end
         `OP_BLOCK_PROGRAM: begin
            op_block = 1'b1;
         end
         default: begin
            op_erase = 1'b0;
            op_block = 1'b0;
         end
      endcase
   end

   // array strobes, registered
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         array_busy_o    <= 1'b0;
         array_erase_o   <= 1'b0;
         array_program_o <= 1'b0;
         array_block_o   <= 1'b0;
         array_addr_o    <= 23'h000000;
         array_data_o    <= 16'h0000;
      end else begin
         array_busy_o    <= start_r;
         array_erase_o   <= start_r && op_erase;
         array_program_o <= start_r && !op_erase;
         array_block_o   <= start_r && op_block;
         array_addr_o    <= {addr_high_r, addr_low_r};
         array_data_o    <= mem_rdata;
      end
   end

   // register read, zero for unimplemented bits
   always_comb begin
      rd_nxt = 16'h0000;
      unique case (req.addr)
         `OFS_OP_CONTROL: begin
            rd_nxt = {start_r, arm_r, fault_r, 4'h0, term_r, 1'b0, opsel_r}
                     & `OP_CONTROL_MASK;
         end
         `OFS_ADDR_LOW: begin
            rd_nxt = addr_low_r;
         end
         `OFS_ADDR_HIGH: begin
            rd_nxt = {9'h000, addr_high_r};
         end
         default: begin
            rd_nxt = 16'h0000;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         reg_rdata_o <= 16'h0000;
      end else begin
         reg_rdata_o <= req.rd ? rd_nxt : 16'h0000;
      end
   end

endmodule : eeprom_write_unlock_controller

`default_nettype wire

// File: eeprom_write_unlock_controller_tb_top.sv
/*
 self-checking bench for the eeprom write unlock controller.
 assumes the fixed 100000-cycle count, so one full cycle is run.
*/
`default_nettype none
`include "eeprom_unlock_regs.svh"

module eeprom_write_unlock_controller_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic [15:0] reg_addr_i = 16'h0;
   logic [15:0] reg_wdata_i = 16'h0;
   logic        reg_wr_i = 1'b0;
   logic        reg_rd_i = 1'b0;
   logic [15:0] reg_rdata_o;
   logic        tbl_wr_i = 1'b0;
   logic [22:0] tbl_addr_i = 23'h0;
   logic [15:0] tbl_data_i = 16'h0;
   logic        done_clear_i = 1'b0;
   logic        done_flag_o;
   logic        array_busy_o;
   logic        array_erase_o;
   logic        array_program_o;
   logic        array_block_o;
   logic [22:0] array_addr_o;
   logic [15:0] array_data_o;
   int          err_total = 0;
   int          checks_done = 0;
   int          cyc = 0;
   int          n;
   // rows: address, write data, expected read back
   logic [15:0] ra[8] = '{16'h0760, 16'h0760, 16'h0760, 16'h0760,
                          16'h0762, 16'h0764, 16'h0766, 16'h0768};
   logic [15:0] rd[8] = '{16'h400a, 16'h4004, 16'h2104, 16'h1e80,
                          16'hffff, 16'hffff, 16'h0055, 16'h1234};
   logic [15:0] re[8] = '{16'h400a, 16'h4004, 16'h2104, 16'h0000,
                          16'hffff, 16'h007f, 16'h0000, 16'h0000};

   eeprom_write_unlock_controller eeprom_write_unlock_controller_i (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .tbl_wr_i(tbl_wr_i), .tbl_addr_i(tbl_addr_i), .tbl_data_i(tbl_data_i),
      .done_clear_i(done_clear_i), .done_flag_o(done_flag_o), .array_busy_o(array_busy_o),
      .array_erase_o(array_erase_o), .array_program_o(array_program_o),
      .array_block_o(array_block_o), .array_addr_o(array_addr_o),
      .array_data_o(array_data_o)
   );

   always #10 clk_i = ~clk_i;

   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : final_report

   // hang guard, one cycle plus margin
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 120000) begin
         err_total++;
         final_report();
      end
   end

   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      checks_done++;
      if (s !== e) begin
         err_total++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk

   // one bus slot; read data land just after the returning edge
   task automatic bus(input logic w, input logic r, input logic [15:0] a, input logic [15:0] d);
      reg_wr_i <= w;
      reg_rd_i <= r;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge clk_i);
      #1;
   endtask : bus

   task automatic unlock(input logic [15:0] go);
      bus(1'b1, 1'b0, `OFS_UNLOCK_CODE, 16'h0055);
      bus(1'b1, 1'b0, `OFS_UNLOCK_CODE, 16'h00aa);
      bus(1'b1, 1'b0, `OFS_OP_CONTROL, go);
      repeat (2) bus(1'b0, 1'b0, 16'h0, 16'h0);
      bus(1'b0, 1'b1, `OFS_OP_CONTROL, 16'h0);
   endtask : unlock

   initial begin
      repeat (2) @(posedge clk_i);
      #1 rst_n_i = 1'b1;
      bus(1'b0, 1'b1, `OFS_OP_CONTROL, 16'h0);
      chk(reg_rdata_o, 16'h0000);
      for (int i = 0; i < 8; i++) begin
         bus(1'b1, 1'b0, ra[i], rd[i]);
         bus(1'b0, 1'b1, ra[i], 16'h0);
         chk(reg_rdata_o, re[i]);
      end
      $display("register rows done");
      bus(1'b1, 1'b0, `OFS_OP_CONTROL, 16'h0004);
      unlock(16'h8004);
      chk(reg_rdata_o, 16'h0004);
      bus(1'b1, 1'b0, `OFS_OP_CONTROL, 16'h0000);
      unlock(16'hc004);
      chk({15'h0, reg_rdata_o[`BIT_START]}, 16'h0);
      // stray write between the two keys
      bus(1'b1, 1'b0, `OFS_OP_CONTROL, 16'h4004);
      bus(1'b1, 1'b0, `OFS_UNLOCK_CODE, 16'h0055);
      bus(1'b1, 1'b0, `OFS_ADDR_LOW, 16'h0000);
      bus(1'b1, 1'b0, `OFS_UNLOCK_CODE, 16'h00aa);
      bus(1'b1, 1'b0, `OFS_OP_CONTROL, 16'hc004);
      bus(1'b0, 1'b1, `OFS_OP_CONTROL, 16'h0);
      chk({15'h0, reg_rdata_o[`BIT_START] | array_busy_o}, 16'h0);
      $display("refused starts done");
      tbl_addr_i <= 23'h3ffe12;
      tbl_data_i <= 16'h5a5a;
      tbl_wr_i <= 1'b1;
      bus(1'b0, 1'b1, `OFS_OP_CONTROL, 16'h0);
      tbl_wr_i <= 1'b0;
      bus(1'b0, 1'b1, `OFS_ADDR_LOW, 16'h0);
      chk(reg_rdata_o, 16'hfe12);
      bus(1'b0, 1'b1, `OFS_ADDR_HIGH, 16'h0);
      chk(reg_rdata_o, 16'h003f);
      $display("table capture done");
      bus(1'b1, 1'b0, `OFS_OP_CONTROL, 16'h4004);
      unlock(16'hc004);
      chk(reg_rdata_o, 16'hc004);
      chk({15'h0, array_busy_o}, 16'h1);
      chk(array_addr_o[15:0], 16'hfe12);
      chk({9'h0, array_addr_o[22:16]}, 16'h003f);
      chk(array_data_o, 16'h5a5a);
      chk({13'h0, array_erase_o, array_program_o, array_block_o}, 16'h0002);
      // arm dropped mid-cycle must not end it
      bus(1'b1, 1'b0, `OFS_OP_CONTROL, 16'h0004);
      bus(1'b0, 1'b1, `OFS_OP_CONTROL, 16'h0);
      chk(reg_rdata_o, 16'h8004);
      for (n = 0; n < 110000 && done_flag_o !== 1'b1; n++)
         bus(1'b0, 1'b0, 16'h0, 16'h0);
      chk({15'h0, n > 99980 && n < 100010}, 16'h1);
      bus(1'b0, 1'b1, `OFS_OP_CONTROL, 16'h0);
      chk(reg_rdata_o, 16'h0004);
      repeat (5) bus(1'b0, 1'b0, 16'h0, 16'h0);
      chk({15'h0, done_flag_o}, 16'h1);
      done_clear_i <= 1'b1;
      bus(1'b0, 1'b0, 16'h0, 16'h0);
      done_clear_i <= 1'b0;
      bus(1'b0, 1'b0, 16'h0, 16'h0);
      chk({15'h0, done_flag_o}, 16'h0);
      $display("full cycle done");
      final_report();
   end
endmodule : eeprom_write_unlock_controller_tb_top

`default_nettype wire
